// file: hdl/mfr_fault_top.sv
module mfr_fault_top #(
  parameter int PWM_ZERO_CYC = mfr_pkg::PWM_ZERO_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [5:0] short_detect,
  input wire logic sync_lost_detect,
  input wire logic temp_warn_detect,
  input wire logic over_temp_detect,
  input wire logic motor_supply_uv_detect,
  input wire logic pwm_in,
  input wire logic serial_clk,
  input wire logic serial_strobe_n,
  output logic serial_data_out,
  output logic fault_out_n_o,
  output logic fault_out_n_oe,
  output logic [5:0] gate_enable,
  output logic irq
);
  localparam int NIN = 13;

  // Three-stage input filter: a bit rises once stages two and three agree high, falls once they differ
  logic [NIN-1:0] s1_q, s2_q, s3_q, filt_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // Strobe starts at its idle level so release brings no false edge
      s1_q <= mfr_pkg::FILT_RST;
      s2_q <= mfr_pkg::FILT_RST;
      s3_q <= mfr_pkg::FILT_RST;
      filt_q <= mfr_pkg::FILT_RST;
    end else begin
      s1_q <= {serial_strobe_n, serial_clk, pwm_in, motor_supply_uv_detect,
               over_temp_detect, temp_warn_detect, sync_lost_detect, short_detect};
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= (s2_q & s3_q) | (filt_q & ~(s2_q ^ s3_q));
    end
  end

  logic [1:0] ctrl_q;
  logic [11:0] mask_q, irq_stat_q, irq_mask_q, diag_q;
  logic stop_on_fault_enable, direct;
  assign stop_on_fault_enable = ctrl_q[mfr_pkg::CTRL_ESF];
  assign direct = ctrl_q[mfr_pkg::CTRL_DIRECT];

  // Masked detections; a masked diagnostic produces nothing at all
  logic [5:0] short_m;
  logic los_m, tw_m, ot_m, uv_m, pwm_f, sclk_f, strb_f;
  assign short_m = filt_q[5:0] & ~mask_q[5:0];
  assign los_m = filt_q[6] & ~mask_q[mfr_pkg::DG_LOS];
  assign tw_m = filt_q[7] & ~mask_q[mfr_pkg::DG_TW];
  assign ot_m = filt_q[8] & ~mask_q[mfr_pkg::DG_OT];
  assign uv_m = filt_q[9] & ~mask_q[mfr_pkg::DG_UV];
  assign pwm_f = filt_q[10];
  assign sclk_f = filt_q[11];
  assign strb_f = filt_q[12];
  logic short_any;
  assign short_any = |short_m;

  logic pwm_d1_q, sclk_d1_q, strb_d1_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_d1_q <= 1'b0;
      sclk_d1_q <= 1'b0;
      strb_d1_q <= 1'b1;
    end else begin
      pwm_d1_q <= pwm_f;
      sclk_d1_q <= sclk_f;
      strb_d1_q <= strb_f;
    end
  end
  logic pwm_rise, sclk_rise, strb_rise;
  assign pwm_rise = pwm_f & ~pwm_d1_q;
  assign sclk_rise = sclk_f & ~sclk_d1_q;
  assign strb_rise = strb_f & ~strb_d1_q;

  // Serial frame checker and diagnostic shift-out
  logic [4:0] scnt_q;
  logic [15:0] snap_q;
  logic sdo_q, rd_done, se_ev;
  logic [15:0] diag_word;
  assign diag_word = {|diag_q, 3'h0, diag_q};
  assign rd_done = strb_rise & (scnt_q == mfr_pkg::SER_BITS);
  assign se_ev = strb_rise & (scnt_q != mfr_pkg::SER_BITS);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scnt_q <= '0;
      snap_q <= '0;
      sdo_q <= 1'b0;
    end else if (strb_f) begin
      scnt_q <= '0;
      snap_q <= diag_word;
      sdo_q <= diag_word[mfr_pkg::DG_FF];
    end else if (sclk_rise) begin
      if (scnt_q != mfr_pkg::SER_CNT_MAX) begin
        scnt_q <= scnt_q + 5'h01;
      end
      sdo_q <= (scnt_q < 5'h0f) ? snap_q[4'he - scnt_q[3:0]] : 1'b0;
    end
  end
  assign serial_data_out = sdo_q;

  // Latched diagnostics; a new fault in the clearing cycle is kept
  logic [11:0] set_vec;
  assign set_vec = {1'b0, se_ev, uv_m, ot_m, tw_m, los_m, short_m};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      diag_q <= mfr_pkg::DIAG_RST;
    end else begin
      diag_q <= set_vec | (rd_done ? 12'h000 : diag_q);
    end
  end

  // 0% duty: PWM held low long enough
  logic [31:0] zcnt_q;
  logic pwm_zero;
  assign pwm_zero = (zcnt_q == 32'(PWM_ZERO_CYC));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      zcnt_q <= '0;
    end else if (pwm_f) begin
      zcnt_q <= '0;
    end else if (!pwm_zero) begin
      zcnt_q <= zcnt_q + 32'h1;
    end
  end

  // Short-fault shutdown latch, only with stop-on-fault
  logic short_lat_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      short_lat_q <= 1'b0;
    end else if (stop_on_fault_enable && short_any) begin
      short_lat_q <= 1'b1;
    end else if (pwm_zero || rd_done) begin
      short_lat_q <= 1'b0;
    end
  end

  // Gate drive control
  logic all_off;
  logic [5:0] gate_q;
  assign all_off = uv_m | los_m | (stop_on_fault_enable & (ot_m | short_any | short_lat_q));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gate_q <= '0;
    end else if (all_off) begin
      gate_q <= '0;
    end else begin
      // Without stop-on-fault a short switches off only the shorted FETs; the rest of the protection is left to the controller
      gate_q <= ~short_m;
    end
  end
  assign gate_enable = gate_q;

  // Pulse-pattern requests in indirect mode
  logic rep2, rep3, rep4, sing2_ev, sing4_ev;
  logic short_d1_q, tw_d1_q, rep_any_d1_q, pend2_q, pend4_q;
  assign rep2 = stop_on_fault_enable & short_lat_q;
  assign rep3 = los_m;
  assign rep4 = ~stop_on_fault_enable & ot_m;
  assign sing2_ev = ~stop_on_fault_enable & short_any & ~short_d1_q;
  assign sing4_ev = stop_on_fault_enable & tw_m & ~tw_d1_q;
  logic new_ev;
  assign new_ev = sing2_ev | sing4_ev | ((rep2 | rep3 | rep4) & ~rep_any_d1_q);

  mfr_pkg::mfr_pulse_e pst_q;
  logic [2:0] grp_q, pcnt_q, ptgt_q;
  logic prep_q;
  logic rep_now;
  always_comb begin
    unique case (grp_q)
      mfr_pkg::GRP_LOS: rep_now = rep3;
      mfr_pkg::GRP_SHORT: rep_now = rep2;
      default: rep_now = rep4;
    endcase
  end

  logic start;
  logic [2:0] start_grp;
  assign start = !direct &&
    (new_ev || (pst_q == mfr_pkg::PS_IDLE && (rep2 | rep3 | rep4 | pend2_q | pend4_q)));
  always_comb begin
    if (rep3) begin
      start_grp = mfr_pkg::GRP_LOS;
    end else if (rep2 || sing2_ev || pend2_q) begin
      start_grp = mfr_pkg::GRP_SHORT;
    end else begin
      start_grp = mfr_pkg::GRP_TEMP;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      short_d1_q <= 1'b0;
      tw_d1_q <= 1'b0;
      rep_any_d1_q <= 1'b0;
      pend2_q <= 1'b0;
      pend4_q <= 1'b0;
    end else begin
      short_d1_q <= short_any;
      tw_d1_q <= tw_m;
      rep_any_d1_q <= rep2 | rep3 | rep4;
      // Single-shot events survive until their pulse begins, not past it
      pend2_q <= (sing2_ev | pend2_q) & ~(start & start_grp == mfr_pkg::GRP_SHORT);
      pend4_q <= (sing4_ev | pend4_q) & ~(start & start_grp == mfr_pkg::GRP_TEMP);
    end
  end

  // Pulse engine: first active phase ends the current period, then N more
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pst_q <= mfr_pkg::PS_IDLE;
      grp_q <= mfr_pkg::GRP_TEMP;
      pcnt_q <= '0;
      ptgt_q <= '0;
      prep_q <= 1'b0;
    end else if (direct) begin
      pst_q <= mfr_pkg::PS_IDLE;
      pcnt_q <= '0;
    end else if (start) begin
      pst_q <= mfr_pkg::PS_ACTIVE;
      grp_q <= start_grp;
      pcnt_q <= '0;
      ptgt_q <= start_grp + 3'h1;
      prep_q <= (start_grp == mfr_pkg::GRP_LOS) ? rep3 :
                (start_grp == mfr_pkg::GRP_SHORT) ? rep2 : rep4;
    end else if (pwm_rise && pst_q != mfr_pkg::PS_IDLE) begin
      if (pcnt_q + 3'h1 != ptgt_q) begin
        pcnt_q <= pcnt_q + 3'h1;
      end else begin
        pcnt_q <= '0;
        ptgt_q <= grp_q;
        unique case (pst_q)
          mfr_pkg::PS_ACTIVE: pst_q <= prep_q ? mfr_pkg::PS_REST : mfr_pkg::PS_IDLE;
          mfr_pkg::PS_REST: pst_q <= rep_now ? mfr_pkg::PS_ACTIVE : mfr_pkg::PS_IDLE;
          default: pst_q <= mfr_pkg::PS_IDLE;
        endcase
      end
    end
  end

  // Open-drain fault pin: only ever pulls low
  logic fault_any, steady_low, fault_oe_q;
  assign fault_any = short_any | los_m | tw_m | ot_m | uv_m | short_lat_q;
  assign steady_low = uv_m | (stop_on_fault_enable & ot_m);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_oe_q <= 1'b0;
    end else if (direct) begin
      fault_oe_q <= fault_any;
    end else begin
      fault_oe_q <= steady_low | (pst_q == mfr_pkg::PS_ACTIVE) | start;
    end
  end
  assign fault_out_n_o = 1'b0;
  assign fault_out_n_oe = fault_oe_q;

  logic aw_full_q, w_full_q, bvalid_q, rvalid_q, wr_fire;
  logic [7:0] wr_addr_q;
  logic [31:0] wr_data_q, rdata_q;

  // Interrupt status: set by newly latched diagnostics, write one to clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (set_vec & ~diag_q) |
        (irq_stat_q & ~((wr_fire && wr_addr_q == mfr_pkg::OFS_IRQ_STAT) ?
         wr_data_q[11:0] : 12'h000));
    end
  end
  assign irq = |(irq_stat_q & irq_mask_q);

  // AXI4-Lite slave
  logic [1:0] bresp_q, rresp_q;
  logic [3:0] wr_strb_q;
  assign s_axi_awready = !aw_full_q;
  assign s_axi_wready = !w_full_q;
  assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      wr_addr_q <= '0;
      wr_data_q <= '0;
      wr_strb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= mfr_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_full_q) begin
        aw_full_q <= 1'b1;
        wr_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full_q) begin
        w_full_q <= 1'b1;
        wr_data_q <= s_axi_wdata;
        wr_strb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (wr_addr_q == mfr_pkg::OFS_CTRL || wr_addr_q == mfr_pkg::OFS_MASK ||
                    wr_addr_q == mfr_pkg::OFS_IRQ_STAT || wr_addr_q == mfr_pkg::OFS_IRQ_MASK ||
                    wr_addr_q == mfr_pkg::OFS_DIAG || wr_addr_q == mfr_pkg::OFS_STATE) ?
                   mfr_pkg::RESP_OKAY : mfr_pkg::RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // Writable registers; byte lanes above the low byte pair are ignored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= mfr_pkg::CTRL_RST;
      mask_q <= mfr_pkg::MASK_RST;
      irq_mask_q <= mfr_pkg::IRQ_MASK_RST;
    end else if (wr_fire) begin
      if (wr_addr_q == mfr_pkg::OFS_CTRL && wr_strb_q[0]) begin
        ctrl_q <= wr_data_q[1:0];
      end
      if (wr_addr_q == mfr_pkg::OFS_MASK) begin
        if (wr_strb_q[0]) mask_q[7:0] <= wr_data_q[7:0] & mfr_pkg::MASK_WR[7:0];
        if (wr_strb_q[1]) mask_q[11:8] <= wr_data_q[11:8] & mfr_pkg::MASK_WR[11:8];
      end
      if (wr_addr_q == mfr_pkg::OFS_IRQ_MASK) begin
        if (wr_strb_q[0]) irq_mask_q[7:0] <= wr_data_q[7:0];
        if (wr_strb_q[1]) irq_mask_q[11:8] <= wr_data_q[11:8];
      end
    end
  end

  assign s_axi_arready = !rvalid_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= mfr_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rresp_q <= mfr_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        mfr_pkg::OFS_CTRL: rdata_q <= {30'h0, ctrl_q};
        mfr_pkg::OFS_MASK: rdata_q <= {20'h0, mask_q};
        mfr_pkg::OFS_DIAG: rdata_q <= {16'h0, diag_word};
        mfr_pkg::OFS_STATE: rdata_q <= {16'h0, short_lat_q, fault_oe_q, 4'h0, gate_q, pst_q, prep_q};
        mfr_pkg::OFS_IRQ_STAT: rdata_q <= {20'h0, irq_stat_q};
        mfr_pkg::OFS_IRQ_MASK: rdata_q <= {20'h0, irq_mask_q};
        default: begin
          rdata_q <= '0;
          rresp_q <= mfr_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  AST_DIRECT_LOW: assert property (@(posedge aclk) disable iff (!aresetn)
    direct && fault_any |=> fault_out_n_oe) else $error("direct fault not driven low");
  AST_STEADY_UV: assert property (@(posedge aclk) disable iff (!aresetn)
    uv_m ##1 uv_m |-> fault_out_n_oe) else $error("undervoltage pin not low");
  AST_PULSE_START: assert property (@(posedge aclk) disable iff (!aresetn)
    start |=> fault_out_n_oe && pst_q == mfr_pkg::PS_ACTIVE) else $error("pulse not started");
  AST_FF: assert property (@(posedge aclk) disable iff (!aresetn)
    |set_vec |=> diag_word[mfr_pkg::DG_FF])
    else $error("common flag not set");
  AST_FIRST_BIT: assert property (@(posedge aclk) disable iff (!aresetn)
    strb_f |=> serial_data_out == $past(diag_word[mfr_pkg::DG_FF])) else $error("first bit wrong");
  AST_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_done && set_vec == 12'h000 |=> diag_q == 12'h000) else $error("diag not cleared");
  AST_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    !rd_done |=> (diag_q & $past(diag_q)) == $past(diag_q)) else $error("diag bit lost");
  AST_ESF_STOP: assert property (@(posedge aclk) disable iff (!aresetn)
    stop_on_fault_enable && (ot_m || short_any) |=> gate_enable == 6'h00) else $error("gates not off");
  AST_SHORT_KEEP: assert property (@(posedge aclk) disable iff (!aresetn)
    short_lat_q && !pwm_zero && !rd_done |=> short_lat_q) else $error("short latch dropped");
  AST_UV_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
    uv_m |=> gate_enable == 6'h00) else $error("gates on in undervoltage");
  AST_MASK: assert property (@(posedge aclk) disable iff (!aresetn)
    mask_q[mfr_pkg::DG_TW] && !diag_q[mfr_pkg::DG_TW] |=> !diag_q[mfr_pkg::DG_TW])
    else $error("masked diagnostic latched");
  AST_SERR: assert property (@(posedge aclk) disable iff (!aresetn)
    se_ev |=> diag_q[mfr_pkg::DG_SE] && diag_word[mfr_pkg::DG_FF]) else $error("serial error not flagged");
endmodule

// file: hdl/mfr_pkg.sv
package mfr_pkg;
  // Register map, byte addresses on a 32-bit AXI4-Lite bus
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MASK = 8'h04;
  localparam logic [7:0] OFS_DIAG = 8'h08;
  localparam logic [7:0] OFS_STATE = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

  // Control register fields
  localparam int CTRL_ESF = 0;
  localparam int CTRL_DIRECT = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;

  // Diagnostic word bit positions (latched bits in the low 12, DG_FF their OR at bit 15)
  localparam int NUM_FET = 6;
  localparam int DG_LOS = 6;
  localparam int DG_TW = 7;
  localparam int DG_OT = 8;
  localparam int DG_UV = 9;
  localparam int DG_SE = 10;
  localparam int DG_POR = 11;
  localparam int DG_W = 12;
  localparam int DG_FF = 15;
  localparam logic [11:0] DIAG_RST = 12'h800;
  // Input filter after reset: serial strobe idles high, all else low
  localparam logic [12:0] FILT_RST = 13'h1000;
  localparam logic [11:0] MASK_RST = 12'h000;
  localparam logic [11:0] IRQ_MASK_RST = 12'h000;
  // Serial error and power-on bits cannot be masked
  localparam logic [11:0] MASK_WR = 12'h3ff;

  // Serial frame length in clock edges
  localparam logic [4:0] SER_BITS = 5'h10;
  localparam logic [4:0] SER_CNT_MAX = 5'h11;

  // Pulse-group lengths in PWM periods
  localparam logic [2:0] GRP_SHORT = 3'h2;
  localparam logic [2:0] GRP_LOS = 3'h3;
  localparam logic [2:0] GRP_TEMP = 3'h4;

  // Time the PWM input must stay low to count as 0% duty
  localparam int CLK_MHZ = 250;
  localparam int PWM_ZERO_TIME_US = 100;
  localparam int PWM_ZERO_CYCLES = PWM_ZERO_TIME_US * CLK_MHZ;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    PS_IDLE = 3'b001,
    PS_ACTIVE = 3'b010,
    PS_REST = 3'b100
  } mfr_pulse_e;
endpackage

// file: test/mfr_ctrl_model.sv
module mfr_ctrl_model #(
  parameter int PER = 48
) (
  input wire logic aclk,
  input wire logic pwm_run,
  input wire logic serial_data_out,
  input wire logic fault_out_n_o,
  input wire logic fault_out_n_oe,
  output logic pwm_in,
  output logic serial_clk,
  output logic serial_strobe_n,
  output logic fault_line
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt = 0;

  // Board pull-up on the shared open-drain wire
  assign fault_line = fault_out_n_oe ? fault_out_n_o : 1'b1;

  always @(posedge aclk) begin
    cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
    // Holding 0% duty is how this controller stops the stage on a fault
    pwm_in <= pwm_run && (cnt < PER / 2);
  end

  initial begin
    pwm_in = 1'b0;
    serial_clk = 1'b0;
    serial_strobe_n = 1'b1;
  end

  // Clock stands still between frames; a count other than 16 is a bad frame
  task automatic frame(input int rises, output logic [15:0] w);
    int i;
    w = 16'h0;
    @(posedge aclk);
    serial_strobe_n <= 1'b0;
    w[15] = serial_data_out;
    repeat (12) @(posedge aclk);
    for (i = 1; i <= rises; i++) begin
      serial_clk <= 1'b1;
      repeat (12) @(posedge aclk);
      if (i < 16) w[15 - i] = serial_data_out;
      serial_clk <= 1'b0;
      repeat (12) @(posedge aclk);
    end
    serial_strobe_n <= 1'b1;
    repeat (12) @(posedge aclk);
  endtask
endmodule

// file: test/test_motor_fault_reporting.sv
module test_motor_fault_reporting;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk;
  logic aresetn;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, rsp;
  logic [5:0] short_det, gate_en;
  logic sync_lost, tw, ot, uv, pwm_in, pwm_d, pwm_run;
  logic sclk, strb_n, sdo, f_o, f_oe, f_line, irq;
  logic [15:0] sw;
  int r;
  int error_cnt = 0;
  int cmp_count = 0;
  logic [7:0] rofs [4] = '{mfr_pkg::OFS_CTRL, mfr_pkg::OFS_MASK, mfr_pkg::OFS_DIAG,
    mfr_pkg::OFS_IRQ_MASK};
  logic [31:0] rexp [4] = '{32'h0, 32'h0, 32'h8800, 32'h0};

  mfr_fault_top #(.PWM_ZERO_CYC(50)) mfr_fault_top_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .short_detect(short_det), .sync_lost_detect(sync_lost), .temp_warn_detect(tw),
    .over_temp_detect(ot), .motor_supply_uv_detect(uv), .pwm_in(pwm_in), .serial_clk(sclk),
    .serial_strobe_n(strb_n), .serial_data_out(sdo), .fault_out_n_o(f_o),
    .fault_out_n_oe(f_oe), .gate_enable(gate_en), .irq(irq)
  );

  mfr_ctrl_model mfr_ctrl_model_i (
    .aclk(aclk), .pwm_run(pwm_run), .serial_data_out(sdo), .fault_out_n_o(f_o),
    .fault_out_n_oe(f_oe), .pwm_in(pwm_in), .serial_clk(sclk), .serial_strobe_n(strb_n),
    .fault_line(f_line)
  );

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  always @(posedge aclk) pwm_d <= pwm_in;

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    {uv, ot, tw, sync_lost, short_det} <= 10'h0;
    pwm_run <= 1'b1;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    // Let the input filters flush before the first stimulus
    repeat (6) @(posedge aclk);
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask

  // Counts raw PWM rises while the pin stays at one level, capped at 8
  task automatic phase(input logic lvl);
    r = 0;
    while (f_oe === lvl && r < 8) begin
      @(posedge aclk);
      if (pwm_in && !pwm_d) r++;
    end
  endtask

  task automatic run_pat(input logic [31:0] ctrl, input logic [9:0] flt, input int a1,
      input int r1, input int a2, input logic [5:0] gexp);
    do_reset();
    axi_wr(mfr_pkg::OFS_CTRL, ctrl);
    // Fault lands mid low phase so no PWM rise is still inside the filter
    while (pwm_in !== 1'b1) @(posedge aclk);
    while (pwm_in !== 1'b0) @(posedge aclk);
    repeat (4) @(posedge aclk);
    {uv, ot, tw, sync_lost, short_det} <= flt;
    repeat (8) @(posedge aclk);
    chk("fault line", {31'h0, f_line}, 32'h0);
    phase(1'b1);
    chk("active periods", r, a1);
    phase(1'b0);
    chk("released periods", r, r1);
    if (a2 > 0) begin
      phase(1'b1);
      chk("repeat periods", r, a2);
    end
    chk("gates", {26'h0, gate_en}, {26'h0, gexp});
  endtask

  initial begin
    r = 0;
    aresetn = 1'b0;
    awaddr = 8'h0;
    araddr = 8'h0;
    wdata = 32'h0;
    wstrb = 4'hf;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    {uv, ot, tw, sync_lost, short_det} = 10'h0;
    pwm_run = 1'b1;
    do_reset();
    chk("pin after reset", {31'h0, f_oe}, 32'h0);
    foreach (rofs[i]) begin
      axi_rd(rofs[i]);
      chk("reset value", rd, rexp[i]);
    end
    axi_rd(8'h20);
    chk("unmapped read", {30'h0, rsp}, {30'h0, mfr_pkg::RESP_SLVERR});
    axi_wr(8'h24, 32'h1);
    chk("unmapped write", {30'h0, rsp}, {30'h0, mfr_pkg::RESP_SLVERR});
    axi_wr(mfr_pkg::OFS_MASK, 32'hfff);
    axi_rd(mfr_pkg::OFS_MASK);
    chk("mask readback", rd, 32'h3ff);
    axi_wr(mfr_pkg::OFS_MASK, 32'h0);
    mfr_ctrl_model_i.frame(16, sw);
    chk("serial word", {16'h0, sw}, 32'h8800);
    axi_rd(mfr_pkg::OFS_DIAG);
    chk("diag after read", rd, 32'h0);
    axi_wr(mfr_pkg::OFS_IRQ_MASK, 32'hfff);
    tw <= 1'b1;
    repeat (12) @(posedge aclk);
    chk("irq", {31'h0, irq}, 32'h1);
    chk("warning pin", {31'h0, f_oe}, 32'h0);
    axi_rd(mfr_pkg::OFS_DIAG);
    chk("diag warning", rd, 32'h8080);
    axi_wr(mfr_pkg::OFS_IRQ_STAT, 32'hfff);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    do_reset();
    axi_wr(mfr_pkg::OFS_CTRL, 32'h2);
    axi_wr(mfr_pkg::OFS_MASK, 32'h80);
    tw <= 1'b1;
    repeat (12) @(posedge aclk);
    chk("masked pin", {31'h0, f_oe}, 32'h0);
    axi_rd(mfr_pkg::OFS_DIAG);
    chk("masked diag", rd, 32'h8800);
    axi_wr(mfr_pkg::OFS_MASK, 32'h0);
    repeat (12) @(posedge aclk);
    chk("direct pin", {31'h0, f_oe}, 32'h1);
    axi_rd(mfr_pkg::OFS_DIAG);
    chk("direct diag", rd, 32'h8880);
    run_pat(32'h0, 10'h040, 4, 3, 3, 6'h00);
    run_pat(32'h0, 10'h100, 5, 4, 4, 6'h3f);
    run_pat(32'h1, 10'h100, 8, 0, 0, 6'h00);
    run_pat(32'h0, 10'h004, 3, 8, 0, 6'h3b);
    run_pat(32'h0, 10'h200, 8, 0, 0, 6'h00);
    uv <= 1'b0;
    repeat (20) @(posedge aclk);
    chk("gates after undervoltage", {26'h0, gate_en}, 32'h3f);
    run_pat(32'h1, 10'h004, 3, 2, 2, 6'h00);
    short_det <= 6'h0;
    repeat (20) @(posedge aclk);
    chk("gates held", {26'h0, gate_en}, 32'h0);
    mfr_ctrl_model_i.frame(15, sw);
    axi_rd(mfr_pkg::OFS_DIAG);
    chk("diag after bad frame", rd, 32'h8c04);
    chk("gates after bad frame", {26'h0, gate_en}, 32'h0);
    pwm_run <= 1'b0;
    repeat (100) @(posedge aclk);
    chk("gates after zero duty", {26'h0, gate_en}, 32'h3f);
    finish_test();
  end

  initial begin
    repeat (30000) @(posedge aclk);
    error_cnt++;
    finish_test();
  end
endmodule
